// file: src/mmr_pkg.sv
package mmr_pkg;
	// apb register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MIDI_IN = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MAIN_VOL = 8'h0c;
	localparam logic [7:0] ADDR_FADER = 8'h10;
	localparam logic [7:0] ADDR_GAIN = 8'h14;
	localparam logic [7:0] ADDR_PRESET = 8'h18;
	localparam logic [7:0] ADDR_EVENT = 8'h1c;
	localparam logic [7:0] ADDR_TX = 8'h20;
	// ctrl bits
	localparam int CTRL_REMOTE_EN = 0;
	localparam int CTRL_STANDALONE = 1;
	localparam int CTRL_LOOP_ARM = 2;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	// status bits
	localparam int ST_DIM = 0;
	localparam int ST_MONO = 1;
	localparam int ST_TALK = 2;
	localparam int ST_SPK_B = 3;
	localparam int ST_TRIM = 4;
	localparam int ST_MUTE = 5;
	localparam int ST_SOLO = 6;
	localparam int ST_LOOP = 7;
	// midi encodings
	localparam logic [3:0] MSG_CC = 4'hb;
	localparam logic [3:0] MSG_NOTE_ON = 4'h9;
	localparam logic [3:0] CHAN_1 = 4'h0;
	localparam logic [3:0] CHAN_3 = 4'h2;
	localparam logic [3:0] CHAN_4 = 4'h3;
	localparam logic [3:0] CHAN_13 = 4'hc;
	localparam logic [6:0] CC_VOLUME = 7'h07;
	localparam logic [6:0] CC_INPUT_GAIN = 7'h09;
	localparam logic [6:0] CC_PRESET = 7'h0c;
	localparam logic [6:0] CC_FADER_LO = 7'h66;
	localparam logic [6:0] CC_FADER_HI = 7'h75;
	localparam logic [6:0] CC_TRIM = 7'h66;
	localparam logic [6:0] CC_SUBMIX_LO = 7'h68;
	localparam logic [6:0] GAIN_MAX = 7'h41;
	localparam logic [6:0] FADER_UNITY = 7'h68;
	localparam logic [6:0] NOTE_DIM = 7'h5d;
	localparam logic [6:0] NOTE_MONO = 7'h2a;
	localparam logic [6:0] NOTE_TALK = 7'h5e;
	localparam logic [6:0] NOTE_RECALL = 7'h5f;
	localparam logic [6:0] NOTE_SPK_B = 7'h32;
	localparam logic [6:0] NOTE_CUE_LO = 7'h3e;
	localparam logic [6:0] NOTE_CUE_HI = 7'h42;
	localparam logic [6:0] NOTE_SNAP_LO = 7'h36;
	localparam logic [6:0] NOTE_SNAP_HI = 7'h3d;
	localparam logic [6:0] NOTE_SETUP_HI = 7'h3b;
	localparam logic [6:0] NOTE_TRIM = 7'h2d;
	localparam logic [6:0] NOTE_MUTE = 7'h2c;
	localparam logic [6:0] NOTE_SOLO = 7'h2b;
	localparam logic [6:0] NOTE_LOOP_MARK = 7'h7f;
	// event codes reported to software
	localparam logic [2:0] EV_NONE = 3'h0;
	localparam logic [2:0] EV_RECALL = 3'h1;
	localparam logic [2:0] EV_SNAP = 3'h2;
	localparam logic [2:0] EV_SETUP = 3'h3;
	localparam logic [2:0] EV_CUE = 3'h4;
	localparam logic [2:0] EV_SUBMIX = 3'h5;
	// loopback marker period
	localparam int CLK_MHZ = 125;
	localparam int LOOP_PERIOD_MS = 500;
	localparam int LOOP_CYCLES = LOOP_PERIOD_MS * 1000 * CLK_MHZ;
	typedef struct packed {
		logic [3:0] kind;
		logic [3:0] chan;
		logic [6:0] num;
		logic [6:0] val;
	} mmr_msg_t;
	typedef struct packed {
		logic [5:0] fader;
		logic [1:0] row;
		logic [6:0] level;
	} mmr_fader_t;
endpackage

// file: src/mmr_parser.sv
`timescale 1ns/100ps
module mmr_parser
	import mmr_pkg::*;
(
	// clocking
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// byte in
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	// message out
	output logic msg_valid,
	output mmr_msg_t msg
);
	logic [7:0] status_reg;
	logic [6:0] first_reg;
	logic have_first_reg;

	// assemble three-byte channel messages with running status
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status_reg <= 8'h00;
			first_reg <= 7'h00;
			have_first_reg <= 1'b0;
			msg_valid <= 1'b0;
			msg <= '0;
		end else if (clk_en) begin
			msg_valid <= 1'b0;
			if (byte_valid) begin
				if (byte_data[7]) begin
					status_reg <= byte_data;
					have_first_reg <= 1'b0;
				end else if (status_reg[7] && !have_first_reg) begin
					first_reg <= byte_data[6:0];
					have_first_reg <= 1'b1;
				end else if (status_reg[7]) begin
					have_first_reg <= 1'b0;
					msg_valid <= 1'b1;
					msg.kind <= status_reg[7:4]; // R6
					msg.chan <= status_reg[3:0]; // R10
					msg.num <= first_reg;
					msg.val <= byte_data[6:0];
				end
			end
		end
	end
endmodule

// file: src/mmr_decoder.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
// Operation
// (R1) cc volume channel 1 sets main output
// (R2) channel 1 notes toggle monitor buttons
// (R3) notes 3e-42 select cue source
// (R4) notes 36-3d load snapshots 1-8
// (R5) notes 2d/2c/2b toggle trim/mute/solo
// (R6) fader command is bx yy zz
// (R7) channels map onto three fader rows
// (R8) controllers 66-75 address one fader each
// (R9) fader value 68 unity, 7f max
// (R10) channel nibble is zero based
// (R11) channel 13 cc 66 toggles trim
// (R12) channel 13 cc 68+ selects submix
// (R13) input gain controller works only when enabled
// (R14) cc 0c channel 3/4 selects presets
// (R15) stand-alone mode responds to notes, transmits
// (R16) stand-alone drops talkback, mono, solo, cues
// (R17) stand-alone keeps faders, mute, routing
// (R18) stand-alone skips middle row fader data
// (R19) stand-alone always in submix view
// (R20) surface controls map to volume, dim, setups
// (R21) stand-alone dim note and setups 1-6
// (R22) marker note returned disables midi control
// (R23) echo feedback of each received command; a marker sent in the same cycle replaces the echo
// (R24) master fader controls main output
// (R25) nonzero note on toggles, off ignored
module mmr_decoder
	import mmr_pkg::*;
#(
	parameter int LOOP_PERIOD = LOOP_CYCLES
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// mixer actions
	output logic fader_valid,
	output mmr_fader_t fader_out,
	output logic [6:0] main_volume,
	// midi output towards surface
	output logic tx_valid,
	output logic [23:0] tx_data
);
	////////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrl_reg;
	logic [7:0] status_reg;
	logic [6:0] main_vol_reg;
	logic [2:0] cue_reg;
	logic [3:0] gain_chan_reg;
	logic [6:0] gain_val_reg;
	logic [3:0] reverb_reg;
	logic [3:0] echo_reg;
	logic [6:0] submix_reg;
	logic [2:0] event_code_reg;
	logic [3:0] event_arg_reg;
	logic [31:0] loop_cnt_reg;
	logic in_valid_reg;
	logic [7:0] in_byte_reg;
	logic msg_valid;
	mmr_msg_t msg;
	logic apb_wr;
	logic apb_rd;

	function automatic logic in_range(input logic [6:0] v, input logic [6:0] lo,
			input logic [6:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;

	mmr_parser u_parser (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.byte_valid(in_valid_reg),
		.byte_data(in_byte_reg),
		.msg_valid(msg_valid),
		.msg(msg)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode conditions
	logic enabled;
	logic standalone;
	logic is_cc;
	logic is_press;
	logic on_ch1;
	logic use_msg;

	assign enabled = ctrl_reg[CTRL_REMOTE_EN] && !status_reg[ST_LOOP];
	assign standalone = ctrl_reg[CTRL_STANDALONE];
	assign is_cc = msg.kind == MSG_CC; // R6
	assign is_press = (msg.kind == MSG_NOTE_ON) && (msg.val != 7'h00); // R25
	assign on_ch1 = msg.chan == CHAN_1; // R10
	assign use_msg = msg_valid && enabled;

	////////////////////////////////////////////////////////////////////////////
	// apb write side and software-held configuration
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_reg <= CTRL_RESET;
			in_valid_reg <= 1'b0;
			in_byte_reg <= 8'h00;
		end else if (clk_en) begin
			in_valid_reg <= 1'b0;
			if (apb_wr && paddr == ADDR_CTRL) begin
				ctrl_reg <= pwdata[7:0];
			end
			if (apb_wr && paddr == ADDR_MIDI_IN) begin
				in_valid_reg <= 1'b1;
				in_byte_reg <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// toggles and loopback flag
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status_reg <= 8'h00;
		end else if (clk_en) begin
			if (apb_wr && paddr == ADDR_CTRL && pwdata[CTRL_REMOTE_EN]) begin
				status_reg[ST_LOOP] <= 1'b0; // R22
			end
			if (msg_valid && ctrl_reg[CTRL_LOOP_ARM] && is_press && on_ch1
					&& msg.num == NOTE_LOOP_MARK) begin
				status_reg[ST_LOOP] <= 1'b1; // R22
			end
			if (use_msg && on_ch1 && is_press) begin
				if (msg.num == NOTE_DIM) begin
					status_reg[ST_DIM] <= !status_reg[ST_DIM]; // R2 R21
				end
				if (!standalone) begin
					if (msg.num == NOTE_MONO) begin
						status_reg[ST_MONO] <= !status_reg[ST_MONO]; // R2 R16
					end
					if (msg.num == NOTE_TALK) begin
						status_reg[ST_TALK] <= !status_reg[ST_TALK]; // R2 R16
					end
					if (msg.num == NOTE_SPK_B) begin
						status_reg[ST_SPK_B] <= !status_reg[ST_SPK_B]; // R2
					end
					if (msg.num == NOTE_TRIM) begin
						status_reg[ST_TRIM] <= !status_reg[ST_TRIM]; // R5
					end
					if (msg.num == NOTE_SOLO) begin
						status_reg[ST_SOLO] <= !status_reg[ST_SOLO]; // R5 R16
					end
				end
				if (msg.num == NOTE_MUTE) begin
					status_reg[ST_MUTE] <= !status_reg[ST_MUTE]; // R5 R17
				end
			end
			if (use_msg && is_cc && msg.chan == CHAN_13 && !standalone) begin
				if (msg.num == CC_TRIM) begin
					status_reg[ST_TRIM] <= !status_reg[ST_TRIM]; // R11
				end else if (msg.num >= CC_SUBMIX_LO) begin
					status_reg[ST_TRIM] <= 1'b0; // R11
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// volume, gain, presets, cue and submix
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			main_vol_reg <= FADER_UNITY;
			cue_reg <= 3'h0;
			gain_chan_reg <= 4'h0;
			gain_val_reg <= 7'h00;
			reverb_reg <= 4'h0;
			echo_reg <= 4'h0;
			submix_reg <= 7'h00;
		end else if (clk_en && use_msg) begin
			if (is_cc && on_ch1 && msg.num == CC_VOLUME) begin
				main_vol_reg <= msg.val; // R1 R24
			end
			if (is_cc && msg.num == CC_INPUT_GAIN && msg.val <= GAIN_MAX) begin
				gain_chan_reg <= msg.chan; // R13
				gain_val_reg <= msg.val; // R13
			end
			if (is_cc && msg.num == CC_PRESET && msg.chan == CHAN_3) begin
				reverb_reg <= msg.val[3:0]; // R14
			end
			if (is_cc && msg.num == CC_PRESET && msg.chan == CHAN_4) begin
				echo_reg <= msg.val[3:0]; // R14
			end
			if (is_cc && msg.chan == CHAN_13 && msg.num >= CC_SUBMIX_LO && !standalone) begin
				submix_reg <= 7'(msg.num - CC_SUBMIX_LO); // R12 R19
			end
			if (is_press && on_ch1 && !standalone
					&& in_range(msg.num, NOTE_CUE_LO, NOTE_CUE_HI)) begin
				cue_reg <= 3'(msg.num - NOTE_CUE_LO); // R3 R16
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one-shot events: recall, snapshot, setup
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			event_code_reg <= EV_NONE;
			event_arg_reg <= 4'h0;
		end else if (clk_en && use_msg) begin
			if (is_press && on_ch1 && !standalone && msg.num == NOTE_RECALL) begin
				event_code_reg <= EV_RECALL; // R2
				event_arg_reg <= 4'h0;
			end else if (is_press && on_ch1 && !standalone
					&& in_range(msg.num, NOTE_SNAP_LO, NOTE_SNAP_HI)) begin
				event_code_reg <= EV_SNAP; // R4
				event_arg_reg <= 4'(msg.num - NOTE_SNAP_LO + 7'h01);
			end else if (is_press && on_ch1 && standalone
					&& in_range(msg.num, NOTE_SNAP_LO, NOTE_SETUP_HI)) begin
				event_code_reg <= EV_SETUP; // R21 R20
				event_arg_reg <= 4'(msg.num - NOTE_SNAP_LO + 7'h01);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fader commands
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fader_valid <= 1'b0;
			fader_out <= '0;
			main_volume <= FADER_UNITY;
		end else if (clk_en) begin
			fader_valid <= 1'b0;
			main_volume <= main_vol_reg;
			if (use_msg && is_cc && msg.chan < CHAN_13
					&& in_range(msg.num, CC_FADER_LO, CC_FADER_HI)
					&& !(standalone && msg.chan[3:2] == 2'b01)) begin
				fader_valid <= 1'b1; // R8 R17 R18
				fader_out.row <= msg.chan[3:2]; // R7
				fader_out.fader <= {msg.chan[1:0], 4'(msg.num - CC_FADER_LO)}; // R8
				fader_out.level <= msg.val; // R9
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// feedback echo and loopback marker transmit
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tx_valid <= 1'b0;
			tx_data <= 24'h000000;
			loop_cnt_reg <= 32'h00000000;
		end else if (clk_en) begin
			tx_valid <= 1'b0;
			if (loop_cnt_reg >= 32'(LOOP_PERIOD - 1)) begin
				loop_cnt_reg <= 32'h00000000;
			end else begin
				loop_cnt_reg <= loop_cnt_reg + 32'h00000001;
			end
			if (ctrl_reg[CTRL_LOOP_ARM] && loop_cnt_reg >= 32'(LOOP_PERIOD - 1)) begin
				tx_valid <= 1'b1; // R22
				tx_data <= {MSG_NOTE_ON, CHAN_1, 1'b0, NOTE_LOOP_MARK, 8'h7f};
			end else if (use_msg && (!standalone || !is_cc || msg.chan[3:2] != 2'b01)) begin
				tx_valid <= 1'b1; // R23 R15 R18
				tx_data <= {msg.kind, msg.chan, 1'b0, msg.num, 1'b0, msg.val};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb read side
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				pslverr <= paddr > ADDR_TX || paddr[1:0] != 2'b00;
			end
			if (apb_rd) begin
				unique case (paddr)
					ADDR_CTRL: prdata <= {24'h0, ctrl_reg};
					ADDR_STATUS: prdata <= {21'h0, cue_reg, status_reg};
					ADDR_MAIN_VOL: prdata <= {25'h0, main_vol_reg};
					ADDR_FADER: prdata <= {17'h0, fader_out};
					ADDR_GAIN: prdata <= {21'h0, gain_chan_reg, gain_val_reg};
					ADDR_PRESET: prdata <= {17'h0, submix_reg, echo_reg, reverb_reg};
					ADDR_EVENT: prdata <= {25'h0, event_code_reg, event_arg_reg};
					ADDR_TX: prdata <= {8'h0, tx_data};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence loop_mark_s;
		msg_valid && ctrl_reg[CTRL_LOOP_ARM] && is_press && on_ch1 && msg.num == NOTE_LOOP_MARK;
	endsequence

	loop_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R22
		(loop_mark_s and clk_en) |=> status_reg[ST_LOOP])
		else $error("loop marker did not block control");
	main_vol_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
		use_msg && clk_en && is_cc && on_ch1 && msg.num == CC_VOLUME
		|=> main_vol_reg == $past(msg.val))
		else $error("main volume not taken");
	dim_toggle_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
		use_msg && clk_en && on_ch1 && is_press && msg.num == NOTE_DIM
		|=> status_reg[ST_DIM] != $past(status_reg[ST_DIM]))
		else $error("dim did not toggle");
	note_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R25
		msg_valid && msg.kind != MSG_NOTE_ON && msg.kind != MSG_CC && clk_en
		|=> $stable(status_reg[ST_DIM]))
		else $error("note off toggled");
	fader_row_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
		fader_valid |-> fader_out.row != 2'b11)
		else $error("fader row out of range");
	standalone_mono_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
		standalone && !$past(apb_wr) |=> $stable(status_reg[ST_MONO]))
		else $error("mono changed in stand-alone");
	gain_limit_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
		gain_val_reg <= GAIN_MAX)
		else $error("gain above limit");
	echo_cmd_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R23
		use_msg && clk_en && !standalone && !ctrl_reg[CTRL_LOOP_ARM] |=> tx_valid)
		else $error("no feedback echo");
	middle_row_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R18
		fader_valid && $past(standalone) |-> fader_out.row != 2'b01)
		else $error("middle row in stand-alone");
endmodule

// file: test/mmr_surface.sv
`timescale 1ns/100ps
// surface model: listens to the feedback stream the decoder sends back
module mmr_surface
	import mmr_pkg::*;
(
	// clocking
	input wire logic sys_clk,
	input wire logic sys_rst,
	// midi from decoder
	input wire logic tx_valid,
	input wire logic [23:0] tx_data,
	// observations for the bench
	output int tx_count,
	output logic [23:0] last_tx,
	output int mk_count,
	output int mk_gap
);
	int cyc;
	int mk_cyc;
	// collect every echoed message
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cyc <= 0;
			tx_count <= 0;
			last_tx <= 24'h0;
			mk_count <= 0;
			mk_cyc <= 0;
			mk_gap <= 0;
		end else begin
			cyc <= cyc + 1;
			if (tx_valid === 1'b1) begin
				tx_count <= tx_count + 1;
				last_tx <= tx_data;
				// marker spacing seen on the wire
				if (tx_data === {MSG_NOTE_ON, CHAN_1, 1'b0, NOTE_LOOP_MARK, 8'h7f}) begin
					mk_count <= mk_count + 1;
					mk_gap <= cyc - mk_cyc;
					mk_cyc <= cyc;
				end
			end
		end
	end
endmodule

// file: test/midi_mixer_remote_decoder_bench.sv
`timescale 1ns/100ps
module midi_mixer_remote_decoder_bench
	import mmr_pkg::*;
;
	logic sys_clk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic rerr, fader_valid, tx_valid;
	mmr_fader_t fader_out, f_last;
	logic [6:0] main_volume;
	logic [23:0] tx_data, last_tx;
	int tx_count, mk_count, mk_gap, f_cnt, fail_count, n_checks;
	logic [6:0] btn [7] = '{NOTE_DIM, NOTE_MONO, NOTE_TALK, NOTE_SPK_B, NOTE_TRIM, NOTE_MUTE,
		NOTE_SOLO};
	logic [3:0] fch [5] = '{4'h0, 4'h1, 4'h4, 4'h8, 4'hb};
	logic [6:0] fcc [5] = '{7'h66, 7'h66, 7'h66, 7'h75, 7'h70};
	logic [6:0] fv [5] = '{7'h68, 7'h00, 7'h7f, 7'h68, 7'h33};
	////////////////////////////////////////////////////////////////
	mmr_decoder #(.LOOP_PERIOD(50)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fader_valid(fader_valid),
		.fader_out(fader_out), .main_volume(main_volume), .tx_valid(tx_valid), .tx_data(tx_data));
	mmr_surface SURF (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_count(tx_count), .last_tx(last_tx), .mk_count(mk_count),
		.mk_gap(mk_gap));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (sys_rst === 1'b1) begin
			f_cnt = 0;
		end else if (fader_valid === 1'b1) begin
			f_cnt++;
			f_last = fader_out;
		end
	end
	////////////////////////////////////////////////////////////////
	task final_report();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer: setup, access until pready, then release
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pready}, 32'h1);
	endtask
	task send(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b);
		xfer(1'b1, ADDR_MIDI_IN, {24'h0, s});
		xfer(1'b1, ADDR_MIDI_IN, {24'h0, a});
		xfer(1'b1, ADDR_MIDI_IN, {24'h0, b});
		repeat (4) @(posedge sys_clk);
	endtask
	task stat(input int b, input logic v);
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk({31'h0, rdat[b]}, {31'h0, v});
	endtask
	function automatic logic [31:0] fx(input logic [3:0] ch, input logic [6:0] cc,
		input logic [6:0] v);
		logic [6:0] k;
		k = cc - CC_FADER_LO;
		return {17'h0, ch[1:0], k[3:0], ch[3:2], v};
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge sys_clk);
		fail_count++;
		final_report();
	end
	initial begin
		int i;
		int c;
		int t;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		fail_count = 0;
		n_checks = 0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		xfer(1'b0, ADDR_CTRL, 32'h0);
		chk({29'h0, rdat[2:0]}, 32'h1);
		xfer(1'b0, 8'h24, 32'h0);
		chk({rdat[31:1], rerr}, 32'h1);
		send(8'hb0, 8'h07, 8'h55);
		chk({25'h0, main_volume}, 32'h55);
		send(8'hb1, 8'h07, 8'h22);
		xfer(1'b0, ADDR_MAIN_VOL, 32'h0);
		chk({25'h0, rdat[6:0]}, 32'h55);
		for (i = 0; i < 5; i++) begin
			c = f_cnt;
			send({MSG_CC, fch[i]}, {1'b0, fcc[i]}, {1'b0, fv[i]});
			chk(32'(f_cnt), 32'(c + 1));
			chk({17'h0, f_last}, fx(fch[i], fcc[i], fv[i]));
			chk({8'h0, last_tx}, {8'h0, MSG_CC, fch[i], 1'b0, fcc[i], 1'b0, fv[i]});
		end
		xfer(1'b0, ADDR_FADER, 32'h0);
		chk(rdat, fx(4'hb, 7'h70, 7'h33));
		c = f_cnt;
		send(8'hb0, 8'h76, 8'h10);
		send(8'hb0, 8'h65, 8'h10);
		chk(32'(f_cnt), 32'(c));
		for (i = 0; i < 7; i++) begin
			send(8'h90, {1'b0, btn[i]}, 8'h7f);
			stat(i, 1'b1);
			send(8'h90, {1'b0, btn[i]}, 8'h00);
			send(8'h80, {1'b0, btn[i]}, 8'h40);
			stat(i, 1'b1);
			send(8'h90, {1'b0, btn[i]}, 8'h7f);
			stat(i, 1'b0);
		end
		for (i = 0; i < 5; i++) begin
			send(8'h90, {1'b0, NOTE_CUE_LO} + 8'(i), 8'h7f);
			xfer(1'b0, ADDR_STATUS, 32'h0);
			chk({29'h0, rdat[10:8]}, 32'(i));
		end
		send(8'h90, {1'b0, NOTE_RECALL}, 8'h7f);
		xfer(1'b0, ADDR_EVENT, 32'h0);
		chk(rdat, {25'h0, EV_RECALL, 4'h0});
		send(8'h90, {1'b0, NOTE_SNAP_HI}, 8'h7f);
		xfer(1'b0, ADDR_EVENT, 32'h0);
		chk(rdat, {25'h0, EV_SNAP, 4'h8});
		send(8'hbc, 8'h66, 8'h00);
		stat(ST_TRIM, 1'b1);
		send(8'hbc, 8'h66, 8'h12);
		stat(ST_TRIM, 1'b0);
		send(8'hbc, 8'h66, 8'h00);
		send(8'hbc, 8'h69, 8'h00);
		stat(ST_TRIM, 1'b0);
		send(8'hb2, 8'h0c, 8'h05);
		send(8'hb3, 8'h0c, 8'h0a);
		xfer(1'b0, ADDR_PRESET, 32'h0);
		chk(rdat, {17'h0, 7'h01, 4'ha, 4'h5});
		send(8'hb8, 8'h09, 8'h41);
		xfer(1'b0, ADDR_GAIN, 32'h0);
		chk({25'h0, rdat[6:0]}, 32'h41);
		send(8'hb8, 8'h09, 8'h42);
		xfer(1'b1, ADDR_CTRL, 32'h0);
		send(8'hb8, 8'h09, 8'h10);
		xfer(1'b0, ADDR_GAIN, 32'h0);
		chk({25'h0, rdat[6:0]}, 32'h41);
		xfer(1'b1, ADDR_CTRL, 32'h5);
		c = 0;
		while (mk_count < 2 && c < 500) begin
			@(posedge sys_clk);
			c++;
		end
		chk(32'(mk_gap), 32'd50);
		send(8'h90, 8'h7f, 8'h7f);
		stat(ST_LOOP, 1'b1);
		send(8'hb0, 8'h07, 8'h11);
		chk({25'h0, main_volume}, 32'h55);
		xfer(1'b1, ADDR_CTRL, 32'h1);
		stat(ST_LOOP, 1'b0);
		send(8'hb0, 8'h07, 8'h11);
		chk({25'h0, main_volume}, 32'h11);
		xfer(1'b1, ADDR_CTRL, 32'h3);
		send(8'h90, {1'b0, NOTE_DIM}, 8'h7f);
		stat(ST_DIM, 1'b1);
		send(8'h90, {1'b0, NOTE_MONO}, 8'h7f);
		stat(ST_MONO, 1'b0);
		send(8'h90, {1'b0, NOTE_CUE_LO}, 8'h7f);
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk({29'h0, rdat[10:8]}, 32'h4);
		send(8'h90, 8'h3a, 8'h7f);
		send(8'h90, {1'b0, NOTE_SNAP_HI}, 8'h7f);
		xfer(1'b0, ADDR_EVENT, 32'h0);
		chk(rdat, {25'h0, EV_SETUP, 4'h5});
		c = f_cnt;
		t = tx_count;
		send(8'hb4, 8'h66, 8'h10);
		chk(32'(f_cnt), 32'(c));
		chk(32'(tx_count), 32'(t));
		send(8'hb8, 8'h66, 8'h20);
		chk({17'h0, f_last}, fx(4'h8, 7'h66, 7'h20));
		xfer(1'b0, ADDR_TX, 32'h0);
		chk(rdat, {8'h0, MSG_CC, 4'h8, 1'b0, 7'h66, 1'b0, 7'h20});
		final_report();
	end
endmodule
